// [core/ssf_cmd_handler.sv]
// Purpose: Range readback sequencer, flash-stored acquisition control, read-mode select
// Assumes: gateIn synchronous to core_clk; item sink may stall with itemReady low
// Notes:   Text formatting (dec/hex) is done downstream from the item flags
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ssf_cmd_handler #(
    parameter int NUM_CHANNELS = 64
) (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic [7:0]         regAddr,
    input  wire logic [31:0]        regWrData,
    input  wire logic               regWrite,
    input  wire logic               regRead,
    output logic [31:0]             regRdData,
    input  wire logic               gateIn,
    output ssf_pkg::ssf_store_s     store,
    output logic [1:0]              readMode,
    output logic                    eccEnable,
    output ssf_pkg::ssf_item_s      item,
    output logic                    itemValid,
    input  wire logic               itemReady,
    output logic                    rangeBusy
);
    localparam logic [5:0] LAST_CHAN = 6'(NUM_CHANNELS - 1);

    ssf_pkg::ssf_acq_e acqState;
    logic [13:0]       endK;
    logic [23:0]       runUs;
    logic [23:0]       offUs;
    logic [4:0]        nameLen;
    logic [31:0]       nameWord [4];
    logic [23:0]       writeAddr;
    logic              ended;
    logic [13:0]       rangeFrom;
    logic [13:0]       rangeTo;
    logic [31:0]       rangeCtrl;
    logic              gatePrev;
    logic [31:0]       tmrCnt;

    logic [23:0]       curNum;
    logic [23:0]       lastNum;
    logic [5:0]        curChan;
    logic [5:0]        firstChan;
    logic [5:0]        lastChan;
    logic              withTimer;
    logic              onTimer;
    logic              hexSel;
    logic              fastSel;

    logic isCmd;
    logic storeEvent;
    logic [23:0] endLimit;
    logic [23:0] next_from;
    logic [23:0] next_to;
    logic [5:0]  next_first;
    logic [5:0]  next_last;
    logic        next_timer;
    logic [31:0] runCyc;
    logic [31:0] offCyc;

    assign isCmd    = regWrite && (regAddr == ssf_pkg::REG_CMD);
    assign endLimit = 24'(endK) * 24'(ssf_pkg::KILO);
    assign runCyc   = 32'(runUs) * 32'(ssf_pkg::CYC_PER_US);
    // Zero off time still leaves a short gap so the counters can latch
    assign offCyc   = (offUs == 24'h000000) ? 32'(ssf_pkg::OFF_MIN_CYC)
                    : 32'(offUs) * 32'(ssf_pkg::CYC_PER_US);

    // Decode of a pending range read request
    always_comb begin
        logic [5:0] rawFirst;
        logic [5:0] rawLast;
        logic [5:0] capLast;
        rawFirst = rangeCtrl[ssf_pkg::CTL_FIRST_LSB +: 6];
        rawLast  = rangeCtrl[ssf_pkg::CTL_LAST_LSB +: 6];
        capLast  = rangeCtrl[ssf_pkg::CTL_EXT_BIT] ? LAST_CHAN : ssf_pkg::ONE_DIGIT_MAX;
        if (rawFirst > capLast) begin
            rawFirst = capLast;
        end
        if (rawLast > capLast) begin
            rawLast = capLast;
        end
        if (rawLast < rawFirst) begin
            rawLast = rawFirst;
        end
        // Both single and two-digit forms enable the timer only on the value one
        next_timer = (rangeCtrl[ssf_pkg::CTL_TSEL_LSB +: 8] == ssf_pkg::TIMER_SEL_ON);
        next_first = rawFirst;
        next_last  = rawLast;
        if (rangeCtrl[ssf_pkg::CTL_LOW8_BIT]) begin
            next_first = 6'h00;
            next_last  = ssf_pkg::LOW8_LAST;
            next_timer = 1'b0;
        end
        if (rangeCtrl[ssf_pkg::CTL_KILO_BIT]) begin
            next_from = 24'(rangeFrom) * 24'(ssf_pkg::KILO);
            next_to   = 24'(rangeTo) * 24'(ssf_pkg::KILO);
        end else begin
            next_from = 24'(rangeFrom);
            next_to   = 24'(rangeTo);
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            endK      <= 14'h0000;
            runUs     <= 24'h000000;
            offUs     <= 24'h000000;
            readMode  <= ssf_pkg::MODE_RAW;
            rangeFrom <= 14'h0000;
            rangeTo   <= 14'h0000;
            rangeCtrl <= 32'h00000000;
        end else if (regWrite) begin
            unique case (regAddr)
                ssf_pkg::REG_END_K: begin
                    endK <= (regWrData > 32'(ssf_pkg::END_K_MAX)) ? ssf_pkg::END_K_MAX
                          : regWrData[13:0];
                end
                ssf_pkg::REG_RUN_US: begin
                    runUs <= regWrData[23:0];
                end
                ssf_pkg::REG_OFF_US: begin
                    offUs <= regWrData[23:0];
                end
                ssf_pkg::REG_READ_MODE: begin
                    // Unsupported codes are ignored so the mode stays meaningful
                    if (regWrData[1:0] != 2'h3) begin
                        readMode <= regWrData[1:0];
                    end
                end
                ssf_pkg::REG_RANGE_FROM: begin
                    rangeFrom <= regWrData[13:0];
                end
                ssf_pkg::REG_RANGE_TO: begin
                    rangeTo <= regWrData[13:0];
                end
                ssf_pkg::REG_RANGE_CTRL: begin
                    rangeCtrl <= regWrData;
                end
                default: begin
                end
            endcase
        end
    end

    // Correction engine enable follows the read mode
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            eccEnable <= 1'b0;
        end else begin
            eccEnable <= (readMode == ssf_pkg::MODE_ECC);
        end
    end

    // Dataset name storage
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            nameLen <= 5'h00;
            for (int i = 0; i < 4; i++) begin
                nameWord[i] <= 32'h00000000;
            end
        end else if (regWrite) begin
            if (regAddr >= ssf_pkg::REG_NAME0 && regAddr <= ssf_pkg::REG_NAME3) begin
                nameWord[regAddr[3:2]] <= regWrData;
            end
            if (regAddr == ssf_pkg::REG_NAME_LEN) begin
                nameLen <= (regWrData > 32'(ssf_pkg::NAME_MAX))
                         ? ssf_pkg::NAME_MAX : regWrData[4:0];
            end
        end
    end

    // Gate edge history
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            gatePrev <= 1'b0;
        end else begin
            gatePrev <= gateIn;
        end
    end

    always_comb begin
        unique case (acqState)
            ssf_pkg::ACQ_LEVEL: storeEvent = gatePrev && !gateIn;
            ssf_pkg::ACQ_EDGE:  storeEvent = !gatePrev && gateIn;
            ssf_pkg::ACQ_TRUN:  storeEvent = (tmrCnt == 32'h00000000);
            default:            storeEvent = 1'b0;
        endcase
    end

    // Acquisition mode sequencer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            acqState <= ssf_pkg::ACQ_IDLE;
            tmrCnt   <= 32'h00000000;
        end else if (isCmd && regWrData[7:0] == ssf_pkg::CMD_STOP) begin
            acqState <= ssf_pkg::ACQ_IDLE;
        end else if (isCmd && regWrData[7:0] == ssf_pkg::CMD_START_LEVEL) begin
            acqState <= ssf_pkg::ACQ_LEVEL;
        end else if (isCmd && regWrData[7:0] == ssf_pkg::CMD_START_EDGE) begin
            acqState <= ssf_pkg::ACQ_EDGE;
        end else if (isCmd && regWrData[7:0] == ssf_pkg::CMD_START_TIMER) begin
            acqState <= ssf_pkg::ACQ_TRUN;
            tmrCnt   <= (runCyc == 32'h00000000) ? 32'h00000000 : runCyc - 32'h00000001;
        end else if (storeEvent && writeAddr >= endLimit) begin
            acqState <= ssf_pkg::ACQ_IDLE;
        end else begin
            unique case (acqState)
                ssf_pkg::ACQ_TRUN: begin
                    if (tmrCnt == 32'h00000000) begin
                        acqState <= ssf_pkg::ACQ_TOFF;
                        tmrCnt   <= offCyc - 32'h00000001;
                    end else begin
                        tmrCnt <= tmrCnt - 32'h00000001;
                    end
                end
                ssf_pkg::ACQ_TOFF: begin
                    if (tmrCnt == 32'h00000000) begin
                        acqState <= ssf_pkg::ACQ_TRUN;
                        tmrCnt   <= (runCyc == 32'h00000000) ? 32'h00000000
                                  : runCyc - 32'h00000001;
                    end else begin
                        tmrCnt <= tmrCnt - 32'h00000001;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Flash record address and store strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            writeAddr <= 24'h000000;
            store     <= '0;
        end else begin
            store.valid <= storeEvent;
            store.mode  <= readMode;
            if (storeEvent) begin
                store.addr <= writeAddr;
                writeAddr  <= writeAddr + 24'h000001;
            end
            // Naming starts a fresh dataset; a coincident store still pulses, but its address increment is superseded
            if (regWrite && regAddr == ssf_pkg::REG_NAME_LEN) begin
                writeAddr <= 24'h000000;
            end
        end
    end

    // End-reached flag: set by hardware, cleared by any start; set wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ended <= 1'b0;
        end else if (storeEvent && writeAddr >= endLimit) begin
            ended <= 1'b1;
        end else if (isCmd && (regWrData[7:0] == ssf_pkg::CMD_START_LEVEL
                            || regWrData[7:0] == ssf_pkg::CMD_START_EDGE
                            || regWrData[7:0] == ssf_pkg::CMD_START_TIMER)) begin
            ended <= 1'b0;
        end
    end

    // Range read sequencer; one item per channel, then the timer if selected
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rangeBusy <= 1'b0;
            itemValid <= 1'b0;
            item      <= '0;
            curNum    <= 24'h000000;
            lastNum   <= 24'h000000;
            curChan   <= 6'h00;
            firstChan <= 6'h00;
            lastChan  <= 6'h00;
            withTimer <= 1'b0;
            onTimer   <= 1'b0;
            hexSel    <= 1'b0;
            fastSel   <= 1'b0;
        end else if (!rangeBusy) begin
            if (itemReady) begin
                itemValid <= 1'b0;
            end
            // A new request is accepted only once the previous last item has been taken, otherwise it is dropped
            if (isCmd && regWrData[7:0] == ssf_pkg::CMD_RANGE_READ
                && (!itemValid || itemReady) && next_from <= next_to) begin
                rangeBusy <= 1'b1;
                curNum    <= next_from;
                lastNum   <= next_to;
                curChan   <= next_first;
                firstChan <= next_first;
                lastChan  <= next_last;
                withTimer <= next_timer;
                onTimer   <= 1'b0;
                hexSel    <= rangeCtrl[ssf_pkg::CTL_HEX_BIT];
                // Fast LAN transfer only applies to the hex form without the low-eight selection
                fastSel   <= rangeCtrl[ssf_pkg::CTL_FAST_BIT] && rangeCtrl[ssf_pkg::CTL_HEX_BIT]
                          && !rangeCtrl[ssf_pkg::CTL_LOW8_BIT];
            end
        end else if (!itemValid || itemReady) begin
            itemValid    <= 1'b1;
            item.dataNum <= curNum;
            item.chan    <= onTimer ? 6'h00 : curChan;
            item.isTimer <= onTimer;
            item.hexFmt  <= hexSel;
            item.fastLan <= fastSel;
            if (onTimer || (curChan == lastChan && !withTimer)) begin
                onTimer <= 1'b0;
                curChan <= firstChan;
                curNum  <= curNum + 24'h000001;
                if (curNum == lastNum) begin
                    rangeBusy <= 1'b0;
                end
            end else if (curChan == lastChan) begin
                onTimer <= 1'b1;
            end else begin
                curChan <= curChan + 6'h01;
            end
        end
    end

    // Register read port, data valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            regRdData <= 32'h00000000;
        end else if (regRead) begin
            regRdData <= 32'h00000000;
            unique case (regAddr)
                ssf_pkg::REG_STATUS: begin
                    regRdData[ssf_pkg::STS_MODE_LSB +: 3] <= acqState;
                    regRdData[ssf_pkg::STS_BUSY_BIT]      <= rangeBusy;
                    regRdData[ssf_pkg::STS_ENDED_BIT]     <= ended;
                end
                ssf_pkg::REG_END_K:      regRdData <= 32'(endK);
                ssf_pkg::REG_RUN_US:     regRdData <= 32'(runUs);
                ssf_pkg::REG_OFF_US:     regRdData <= 32'(offUs);
                ssf_pkg::REG_READ_MODE:  regRdData <= 32'(readMode);
                ssf_pkg::REG_NAME_LEN:   regRdData <= 32'(nameLen);
                ssf_pkg::REG_WRITE_ADDR: regRdData <= 32'(writeAddr);
                ssf_pkg::REG_RANGE_FROM: regRdData <= 32'(rangeFrom);
                ssf_pkg::REG_RANGE_TO:   regRdData <= 32'(rangeTo);
                ssf_pkg::REG_RANGE_CTRL: regRdData <= rangeCtrl;
                default: begin
                    if (regAddr >= ssf_pkg::REG_NAME0 && regAddr <= ssf_pkg::REG_NAME3) begin
                        regRdData <= nameWord[regAddr[3:2]];
                    end
                end
            endcase
        end else begin
            regRdData <= 32'h00000000;
        end
    end
endmodule

// [core/ssf_pkg.sv]
// Purpose: Shared constants and types for the sync acquisition / flash command handler
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes:   Commands arrive as register writes; text parsing lives in the host-side firmware
package ssf_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CMD        = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_END_K      = 8'h08;
    localparam logic [7:0] REG_RUN_US     = 8'h0C;
    localparam logic [7:0] REG_OFF_US     = 8'h10;
    localparam logic [7:0] REG_READ_MODE  = 8'h14;
    localparam logic [7:0] REG_NAME_LEN   = 8'h18;
    localparam logic [7:0] REG_WRITE_ADDR = 8'h1C;
    localparam logic [7:0] REG_NAME0      = 8'h20;
    localparam logic [7:0] REG_NAME3      = 8'h2C;
    localparam logic [7:0] REG_RANGE_FROM = 8'h30;
    localparam logic [7:0] REG_RANGE_TO   = 8'h34;
    localparam logic [7:0] REG_RANGE_CTRL = 8'h38;

    // Command opcodes written to REG_CMD[7:0]
    localparam logic [7:0] CMD_STOP        = 8'h01;
    localparam logic [7:0] CMD_START_LEVEL = 8'h02;
    localparam logic [7:0] CMD_START_EDGE  = 8'h03;
    localparam logic [7:0] CMD_START_TIMER = 8'h04;
    localparam logic [7:0] CMD_RANGE_READ  = 8'h05;

    // Range control field positions
    localparam int CTL_FIRST_LSB = 0;
    localparam int CTL_LAST_LSB  = 8;
    localparam int CTL_TSEL_LSB  = 16;
    localparam int CTL_HEX_BIT   = 24;
    localparam int CTL_KILO_BIT  = 25;
    localparam int CTL_EXT_BIT   = 26;
    localparam int CTL_LOW8_BIT  = 27;
    localparam int CTL_FAST_BIT  = 28;

    // Status field positions
    localparam int STS_MODE_LSB   = 0;
    localparam int STS_BUSY_BIT   = 3;
    localparam int STS_ENDED_BIT  = 4;

    // Values and limits
    localparam logic [7:0]  TIMER_SEL_ON   = 8'h01;
    localparam logic [13:0] END_K_MAX      = 14'h270F;
    localparam logic [4:0]  NAME_MAX       = 5'h10;
    localparam logic [9:0]  KILO           = 10'h3E8;
    localparam logic [5:0]  ONE_DIGIT_MAX  = 6'h09;
    localparam logic [5:0]  LOW8_LAST      = 6'h07;
    localparam logic [1:0]  MODE_RAW       = 2'h0;
    localparam logic [1:0]  MODE_ONE       = 2'h1;
    localparam logic [1:0]  MODE_ECC       = 2'h2;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int NS_PER_US     = 1000;
    localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
    localparam int OFF_MIN_NS    = 120;
    localparam int OFF_MIN_CYC   = (OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {ACQ_IDLE, ACQ_LEVEL, ACQ_EDGE, ACQ_TRUN, ACQ_TOFF} ssf_acq_e;

    typedef struct packed {
        logic [23:0] dataNum;
        logic [5:0]  chan;
        logic        isTimer;
        logic        hexFmt;
        logic        fastLan;
    } ssf_item_s;

    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
        logic [1:0]  mode;
    } ssf_store_s;
endpackage

// [testbench/ssf_cmd_handler_asserts.sv]
// Purpose: Port-level checks for the command handler
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every handler instance; sees ports only
`timescale 1ns/1ps
module ssf_cmd_handler_asserts (
    input wire logic                core_clk,
    input wire logic                sys_rst,
    input wire logic [7:0]          regAddr,
    input wire logic [31:0]         regWrData,
    input wire logic                regWrite,
    input wire logic                regRead,
    input wire logic [31:0]         regRdData,
    input wire logic                gateIn,
    input wire ssf_pkg::ssf_store_s store,
    input wire logic [1:0]          readMode,
    input wire logic                eccEnable,
    input wire ssf_pkg::ssf_item_s  item,
    input wire logic                itemValid,
    input wire logic                itemReady,
    input wire logic                rangeBusy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_ecc_follows_mode: assert property (eccEnable == ($past(readMode) == ssf_pkg::MODE_ECC))
        else $error("correction enable does not track read mode");
    a_mode_readback: assert property (regRead && regAddr == ssf_pkg::REG_READ_MODE
        |=> regRdData == {30'h0, $past(readMode)}) else $error("read mode readback wrong");
    a_mode_write: assert property (regWrite && regAddr == ssf_pkg::REG_READ_MODE
        && regWrData < 32'h3 |=> readMode == $past(regWrData[1:0]))
        else $error("read mode write not taken");
    a_endk_range: assert property (regRead && regAddr == ssf_pkg::REG_END_K
        |=> regRdData <= {18'h0, ssf_pkg::END_K_MAX}) else $error("end address out of range");
    a_store_single: assert property (store.valid |=> !store.valid)
        else $error("store pulse longer than one cycle");
    a_stop_quiet: assert property (regWrite && regAddr == ssf_pkg::REG_CMD
        && regWrData[7:0] == ssf_pkg::CMD_STOP |-> ##2 !store.valid)
        else $error("store after stop");
    a_item_hold: assert property (itemValid && !itemReady |=> itemValid && $stable(item))
        else $error("item changed while stalled");
    a_fast_hex: assert property (itemValid && item.fastLan |-> item.hexFmt)
        else $error("fast mode without hex");
    a_name_addr: assert property (regWrite && regAddr == ssf_pkg::REG_NAME_LEN
        ##1 regRead && regAddr == ssf_pkg::REG_WRITE_ADDR |=> regRdData == 32'h0)
        else $error("write address not cleared by name");
endmodule

bind ssf_cmd_handler ssf_cmd_handler_asserts i_ssf_cmd_handler_asserts (
    .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .gateIn(gateIn),
    .store(store), .readMode(readMode), .eccEnable(eccEnable), .item(item),
    .itemValid(itemValid), .itemReady(itemReady), .rangeBusy(rangeBusy));

// [testbench/ssf_cmd_handler_tb.sv]
// Purpose: Self-checking bench for the command handler
// Assumes: 50 MHz clock, sink model on the item stream
// Notes:   Timer run of 1 us keeps pacing visible in few cycles
`timescale 1ns/1ps
module ssf_cmd_handler_tb;
    logic                core_clk = 1'b0;
    logic                sys_rst = 1'b1;
    logic [7:0]          regAddr = 8'h00;
    logic [31:0]         regWrData = 32'h0;
    logic                regWrite = 1'b0;
    logic                regRead = 1'b0;
    logic                gateIn = 1'b0;
    logic                slow = 1'b0;
    logic [31:0]         regRdData;
    ssf_pkg::ssf_store_s store;
    logic [1:0]          readMode;
    logic                eccEnable;
    ssf_pkg::ssf_item_s  item;
    logic                itemValid;
    logic                itemReady;
    logic                rangeBusy;
    int                  err_total = 0;
    int                  checks_done = 0;
    int                  cyc = 0;
    int                  n;
    logic [31:0]         seed = 32'hDEDA;
    logic [31:0]         v;
    ssf_pkg::ssf_item_s  expQ[$];
    int                  stCyc[$];
    logic [23:0]         stAddr[$];

    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    ssf_cmd_handler i_ssf_cmd_handler (.core_clk(core_clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .gateIn(gateIn), .store(store), .readMode(readMode),
        .eccEnable(eccEnable), .item(item), .itemValid(itemValid), .itemReady(itemReady),
        .rangeBusy(rangeBusy));
    ssf_item_sink i_ssf_item_sink (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
        .itemReady(itemReady));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] ctl(input int fi, input int la, input logic [7:0] ts,
                                        input logic [4:0] fl);
        return {3'h0, fl, ts, 2'h0, la[5:0], 2'h0, fi[5:0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
        regWrite <= w;
        regRead <= !w;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        op(1'b1, a, d);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        op(1'b0, a, 32'h0);
        regRead <= 1'b0;
        #1 v = regRdData;
        chk(nm, e, v);
        @(posedge core_clk);
    endtask
    task automatic pulse(input int w);
        gateIn <= 1'b1;
        repeat (w) @(posedge core_clk);
        gateIn <= 1'b0;
        repeat (w) @(posedge core_clk);
    endtask
    // Range stream model: channels, then timer, ascending numbers
    task automatic rr(input int f, input int t, input logic [31:0] c, input bit dup);
        int k, lo, hi, i, w;
        bit tm, fs;
        k = c[25] ? 1000 : 1;
        hi = c[26] ? 63 : 9;
        if (int'(c[13:8]) < hi) hi = c[13:8];
        lo = c[27] ? 0 : c[5:0];
        if (c[27]) hi = 7;
        tm = !c[27] && c[23:16] == ssf_pkg::TIMER_SEL_ON;
        fs = c[28] && c[24] && !c[27];
        if (f <= t) for (i = f * k; i <= t * k; i++) begin
            for (w = lo; w <= hi; w++) expQ.push_back({i[23:0], w[5:0], 1'b0, c[24], fs});
            if (tm) expQ.push_back({i[23:0], 6'h00, 1'b1, c[24], fs});
        end
        wr(ssf_pkg::REG_RANGE_FROM, f);
        wr(ssf_pkg::REG_RANGE_TO, t);
        wr(ssf_pkg::REG_RANGE_CTRL, c);
        wr(ssf_pkg::REG_CMD, {24'h0, ssf_pkg::CMD_RANGE_READ});
        if (dup) wr(ssf_pkg::REG_CMD, {24'h0, ssf_pkg::CMD_RANGE_READ});
        #1;
        chk("busy", f <= t, rangeBusy);
        for (w = 0; w < 3000 && (rangeBusy || itemValid); w++) begin
            @(posedge core_clk);
            #1;
        end
        chk("range leftover", 0, expQ.size());
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        if (store.valid) begin
            stAddr.push_back(store.addr);
            stCyc.push_back(cyc);
        end
        if (itemValid && itemReady) begin
            checks_done++;
            if (expQ.size() == 0 || item !== expQ[0]) begin
                err_total++;
                $display("BAD item expected %h seen %h", expQ.size() ? expQ[0] : 33'h0, item);
            end
            if (expQ.size() > 0) void'(expQ.pop_front());
        end
    end

    initial begin
        #(20 * 20000);
        err_total++;
        $display("BAD watchdog expected done seen hang");
        finish_test;
    end

    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rdc("status", ssf_pkg::REG_STATUS, 32'h0);
        seed = lfsr(seed);
        wr(ssf_pkg::REG_RUN_US, {8'h0, seed[23:0]});
        rdc("run", ssf_pkg::REG_RUN_US, {8'h0, seed[23:0]});
        seed = lfsr(seed);
        wr(ssf_pkg::REG_OFF_US, {8'h0, seed[23:0]});
        rdc("off", ssf_pkg::REG_OFF_US, {8'h0, seed[23:0]});
        wr(ssf_pkg::REG_END_K, 32'h3FFF);
        rdc("endk", ssf_pkg::REG_END_K, 32'h270F);
        wr(ssf_pkg::REG_NAME_LEN, 32'h14);
        rdc("name len", ssf_pkg::REG_NAME_LEN, 32'h10);
        rdc("unmapped", 8'hFC, 32'h0);
        for (n = 0; n < 4; n++) begin
            wr(ssf_pkg::REG_READ_MODE, n);
            rdc("mode", ssf_pkg::REG_READ_MODE, (n == 3) ? 32'h2 : n);
            chk("ecc", {(n == 3) ? 2'h2 : 2'(n), n >= 2}, {readMode, eccEnable});
        end
        wr(ssf_pkg::REG_READ_MODE, 32'h0);
        $display("test registers done");
        wr(ssf_pkg::REG_END_K, 32'h0);
        wr(ssf_pkg::REG_CMD, {24'h0, ssf_pkg::CMD_START_EDGE});
        rdc("edge state", ssf_pkg::REG_STATUS, 32'h2);
        pulse(3);
        pulse(3);
        chk("end stores", 1, stAddr.size());
        chk("end addr", 0, stAddr[0]);
        rdc("ended", ssf_pkg::REG_STATUS, 32'h10);
        $display("test end address done");
        wr(ssf_pkg::REG_END_K, 32'h1);
        op(1'b1, ssf_pkg::REG_NAME_LEN, 32'h5);
        rdc("addr clear", ssf_pkg::REG_WRITE_ADDR, 32'h0);
        stAddr.delete();
        wr(ssf_pkg::REG_CMD, {24'h0, ssf_pkg::CMD_START_EDGE});
        rdc("restart", ssf_pkg::REG_STATUS, 32'h2);
        for (n = 0; n < 3; n++) pulse(2);
        for (n = 0; n < 3; n++) chk("edge addr", n, stAddr[n]);
        rdc("write addr", ssf_pkg::REG_WRITE_ADDR, 32'h3);
        wr(ssf_pkg::REG_CMD, {24'h0, ssf_pkg::CMD_START_LEVEL});
        gateIn <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("level early", 3, stAddr.size());
        gateIn <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("level addr", 3, stAddr[3]);
        wr(ssf_pkg::REG_CMD, {24'h0, ssf_pkg::CMD_STOP});
        pulse(3);
        chk("stopped", 4, stAddr.size());
        rdc("stop state", ssf_pkg::REG_STATUS, 32'h0);
        $display("test gate modes done");
        wr(ssf_pkg::REG_RUN_US, 32'h1);
        wr(ssf_pkg::REG_OFF_US, 32'h0);
        stCyc.delete();
        wr(ssf_pkg::REG_CMD, {24'h0, ssf_pkg::CMD_START_TIMER});
        repeat (200) @(posedge core_clk);
        wr(ssf_pkg::REG_CMD, {24'h0, ssf_pkg::CMD_STOP});
        chk("timer gap", 56, stCyc[1] - stCyc[0]);
        chk("timer gap2", 56, stCyc[2] - stCyc[1]);
        $display("test timer done");
        slow <= 1'b1;
        rr(3, 5, ctl(2, 4, 8'h01, 5'h00), 1'b1);
        rr(0, 2, ctl(5, 12, 8'h01, 5'h01), 1'b0);
        rr(1, 2, ctl(10, 20, 8'h01, 5'h15), 1'b0);
        slow <= 1'b0;
        rr(2, 2, ctl(0, 1, 8'h00, 5'h06), 1'b0);
        rr(4, 6, ctl(3, 5, 8'h01, 5'h19), 1'b0);
        rr(5, 3, ctl(0, 2, 8'h00, 5'h00), 1'b0);
        for (n = 0; n < 4; n++) begin
            seed = lfsr(seed);
            slow <= seed[12];
            rr(seed[2:0], seed[2:0] + seed[4:3], ctl(seed[7:5], 30 + seed[9:8], 8'h11,
               {1'b0, 1'b0, 1'b1, 1'b0, seed[10]}), 1'b0);
        end
        $display("test range reads done");
        finish_test;
    end
endmodule

// [testbench/ssf_item_sink.sv]
// Purpose: Downstream item sink model
// Assumes: slow high selects an irregular stall pattern
// Notes:   Prompt when slow is low, so both paces are covered
`timescale 1ns/1ps
module ssf_item_sink (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic slow,
    output logic      itemReady
);
    logic [7:0] pat;
    always_ff @(posedge core_clk) begin
        if (sys_rst) pat <= 8'h5B;
        else pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
    end
    assign itemReady = !slow || pat[0];
endmodule
